// [dv/host_model.sv]
// Host computer model issuing commands and connection attempts
`include "maint_port_regs.vh"
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_cmd_ready,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_conn_grant,
  input  wire logic [63:0] i_rsp_data,
  output logic             o_cmd_valid,
  output logic             o_conn_req,
  output logic [63:0]      o_cmd_data,
  output logic [7:0]       o_cmd_len,
  output logic [31:0]      o_conn_host
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmd_valid = 0;
    o_conn_req = 0;
    o_cmd_data = '1;
    o_cmd_len = 0;
    o_conn_host = '1;
  end
  function automatic logic [63:0] frame(input logic [7:0] opc, opnd);
    return {`MP_RSVD_BYTE, `MP_MSG_TYPE, opc, opnd, 32'h0};
  endfunction
  // Ready seen high at a falling edge means the next rising edge takes it
  task automatic xfer(input logic [63:0] d, input logic [7:0] len, output logic [63:0] rsp);
    rsp = 'x;
    do @(negedge i_clk); while (i_cmd_ready !== 1'b1);
    o_cmd_valid = 1;
    o_cmd_data = d;
    o_cmd_len = len;
    @(negedge i_clk);
    o_cmd_valid = 0;
    // Released data must not look valid
    o_cmd_data = ~d;
    repeat (4) begin
      @(negedge i_clk);
      if (i_rsp_valid === 1'b1) rsp = i_rsp_data;
    end
  endtask
  task automatic connect(input logic [31:0] h, output logic g);
    @(negedge i_clk);
    o_conn_req = 1;
    o_conn_host = h;
    #1 g = i_conn_grant;
    @(negedge i_clk);
    o_conn_req = 0;
    o_conn_host = ~h;
  endtask
endmodule // host_model

// [dv/maint_port_checker_sva.sv]
// Checker for maintenance port ownership and reply timing
module maint_port_checker #(
  parameter HOST_W = 32
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_cmd_valid,
  input wire logic              o_cmd_ready,
  input wire logic              o_rsp_valid,
  input wire logic [63:0]       i_cmd_data,
  input wire logic [63:0]       o_rsp_data,
  input wire logic              i_conn_req,
  input wire logic              o_conn_grant,
  input wire logic              o_conn_refuse,
  input wire logic              o_port_reset,
  input wire logic              o_port_open,
  input wire logic              o_owner_valid,
  input wire logic [HOST_W-1:0] i_conn_host,
  input wire logic [HOST_W-1:0] o_owner_host
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RSP_LAT: assert property (i_cmd_valid && o_cmd_ready |-> !o_rsp_valid ##2 o_rsp_valid)
    else $error("reply not two cycles after take");
  AST_ECHO: assert property (o_rsp_valid |-> o_rsp_data[63:32] == $past(i_cmd_data[63:32], 2))
    else $error("reply header not echoed");
  AST_NO_OLD: assert property (o_rsp_valid |-> o_rsp_data[23:16] != 8'h03
    && o_rsp_data[31:24] == 8'h00 && o_rsp_data[15:0] == 16'h0000)
    else $error("reply status field malformed");
  AST_SOLE: assert property (o_conn_grant && o_owner_valid |-> i_conn_host == o_owner_host)
    else $error("second host granted");
  AST_REFUSE: assert property (i_conn_req |-> o_conn_grant ^ o_conn_refuse)
    else $error("attempt not answered once");
  AST_CLOSED: assert property (i_conn_req && !o_port_open |-> o_conn_refuse)
    else $error("closed port granted");
  AST_KEEP: assert property (o_owner_valid |=> o_port_reset
    || (o_owner_valid && $stable(o_owner_host)))
    else $error("owner lost without release");
  AST_PRST: assert property (o_port_reset |-> o_rsp_valid && !o_port_open && !o_owner_valid)
    else $error("port reset without close");
  AST_PRST_FIRE: assert property (o_rsp_valid && o_rsp_data[47:32] == 16'hff01
    && o_rsp_data[23:16] == 8'h00 |-> o_port_reset)
    else $error("release reply without port reset");
  AST_REARM: assert property (o_rsp_valid && o_rsp_data[47:32] == 16'hff00
    && o_rsp_data[23:16] == 8'h00 |-> o_port_open && !o_port_reset)
    else $error("re-arm reply with port closed");
  AST_FOREIGN: assert property (i_conn_req && o_owner_valid && i_conn_host != o_owner_host
    |-> o_conn_refuse ##1 (o_port_reset || (o_owner_valid && $stable(o_owner_host))))
    else $error("foreign host disturbed owner");
endmodule // maint_port_checker

bind maint_port_owner maint_port_checker #(
  .HOST_W (HOST_W)
) maint_port_checker_inst (
  .i_clk         (i_clk),
  .i_rst_n       (i_rst_n),
  .i_cmd_valid   (i_cmd_valid),
  .o_cmd_ready   (o_cmd_ready),
  .o_rsp_valid   (o_rsp_valid),
  .i_cmd_data    (i_cmd_data),
  .o_rsp_data    (o_rsp_data),
  .i_conn_req    (i_conn_req),
  .o_conn_grant  (o_conn_grant),
  .o_conn_refuse (o_conn_refuse),
  .o_port_reset  (o_port_reset),
  .o_port_open   (o_port_open),
  .o_owner_valid (o_owner_valid),
  .i_conn_host   (i_conn_host),
  .o_owner_host  (o_owner_host)
);

// [dv/testbench.sv]
// Self-checking bench for the maintenance port owner
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst_n, i_cmd_modify, i_tbl_wr;
  logic [10:0] i_cmd_fault;
  logic [7:0]  i_tbl_opcode;
  logic [1:0]  i_tbl_data;
  wire         i_cmd_valid, i_conn_req, o_cmd_ready, o_rsp_valid, o_conn_grant;
  wire         o_conn_refuse, o_port_reset, o_port_open, o_owner_valid;
  wire [63:0]  i_cmd_data, o_rsp_data;
  wire [7:0]   i_cmd_len;
  wire [31:0]  i_conn_host, o_owner_host;
  wire [15:0]  o_port_num;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  logic        g;

  maint_port_owner maint_port_owner_inst (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_cmd_valid   (i_cmd_valid),
    .o_cmd_ready   (o_cmd_ready),
    .i_cmd_data    (i_cmd_data),
    .i_cmd_len     (i_cmd_len),
    .i_cmd_modify  (i_cmd_modify),
    .i_cmd_fault   (i_cmd_fault),
    .o_rsp_valid   (o_rsp_valid),
    .o_rsp_data    (o_rsp_data),
    .i_conn_req    (i_conn_req),
    .i_conn_host   (i_conn_host),
    .o_conn_grant  (o_conn_grant),
    .o_conn_refuse (o_conn_refuse),
    .o_port_reset  (o_port_reset),
    .o_port_open   (o_port_open),
    .o_owner_valid (o_owner_valid),
    .o_owner_host  (o_owner_host),
    .o_port_num    (o_port_num),
    .i_tbl_wr      (i_tbl_wr),
    .i_tbl_opcode  (i_tbl_opcode),
    .i_tbl_data    (i_tbl_data)
  );
  host_model host_model_inst (.i_clk(i_clk), .i_cmd_ready(o_cmd_ready),
    .i_rsp_valid(o_rsp_valid), .i_conn_grant(o_conn_grant), .i_rsp_data(o_rsp_data),
    .o_cmd_valid(i_cmd_valid), .o_conn_req(i_conn_req), .o_cmd_data(i_cmd_data),
    .o_cmd_len(i_cmd_len), .o_conn_host(i_conn_host));

  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cmd(input logic [63:0] d, input logic [7:0] len, code);
    logic [63:0] r;
    host_model_inst.xfer(d, len, r);
    chk("reply", {d[63:32], 8'h00, code, 16'h0000}, r);
  endtask
  function automatic logic [63:0] fr(input logic [7:0] opc, opnd);
    return host_model_inst.frame(opc, opnd);
  endfunction

  task automatic t_owner;
    host_model_inst.connect(32'ha, g);
    chk("grant_a", 1, g);
    chk("owner", {1'b1, 32'ha}, {o_owner_valid, o_owner_host});
    host_model_inst.connect(32'hb, g);
    chk("grant_b", 0, g);
    cmd(fr(8'h10, 8'h00), 8, 8'h00);
    host_model_inst.connect(32'ha, g);
    chk("regrant_a", {1'b1, 32'ha}, {g, o_owner_host});
  endtask
  task automatic t_status;
    logic [7:0] codes [11] = '{8'h04, 8'h05, 8'h16, 8'h0f, 8'h10, 8'h02,
                               8'h14, 8'h11, 8'h12, 8'h06, 8'h07};
    for (int i = 0; i < 11; i++) begin
      i_cmd_fault = 11'h001 << i;
      cmd(fr(8'h10, 8'(i)), 8, codes[i]);
    end
    i_cmd_fault = 11'h003;
    cmd(fr(8'h10, 8'h00), 8, 8'h04);
    cmd(fr(8'h10, 8'h00), 7, 8'h13);
    i_cmd_fault = 0;
    cmd(fr(8'h10, 8'h00), 7, 8'h13);
    cmd(fr(8'h10, 8'h00), 9, 8'h15);
    cmd({8'h00, 8'h03, 8'h10, 8'h00, 32'h0}, 8, 8'h20);
    cmd({8'h01, 8'h02, 8'h10, 8'h00, 32'h0}, 8, 8'h20);
    cmd({8'h00, 8'h02, 8'h10, 8'h00, 32'h1}, 8, 8'h20);
    cmd(fr(8'h12, 8'h00), 8, 8'h08);
    i_cmd_modify = 1;
    cmd(fr(8'h11, 8'h00), 8, 8'h0e);
    cmd(fr(8'h10, 8'h00), 8, 8'h00);
    i_cmd_modify = 0;
  endtask
  task automatic t_handover;
    cmd(fr(8'hff, 8'h01), 8, 8'h00);
    chk("closed", 2'b00, {o_port_open, o_owner_valid});
    host_model_inst.connect(32'hb, g);
    chk("grant_closed", 0, g);
    cmd(fr(8'hff, 8'h02), 8, 8'h20);
    chk("still_closed", 0, o_port_open);
    cmd(fr(8'hff, 8'h00), 8, 8'h00);
    host_model_inst.connect(32'hb, g);
    chk("owner_b", {2'b11, 32'hb}, {g, o_owner_valid, o_owner_host});
    host_model_inst.connect(32'ha, g);
    chk("grant_old", 0, g);
    cmd(fr(8'hff, 8'h00), 8, 8'h00);
    chk("rearm_owned", {1'b1, 32'hb}, {o_owner_valid, o_owner_host});
    // second change of host repeats both steps
    cmd(fr(8'hff, 8'h01), 8, 8'h00);
    cmd(fr(8'hff, 8'h00), 8, 8'h00);
    host_model_inst.connect(32'ha, g);
    chk("owner_a_again", {2'b11, 32'ha}, {g, o_owner_valid, o_owner_host});
    chk("udp_port", 16'd7775, o_port_num);
  endtask
  task automatic t_power;
    // Supply cycle drops the owner and reopens the port
    i_rst_n = 0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1;
    chk("power_cycle", 2'b10, {o_port_open, o_owner_valid});
    host_model_inst.connect(32'hb, g);
    chk("owner_after_power", {2'b11, 32'hb}, {g, o_owner_valid, o_owner_host});
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    i_rst_n = 0;
    i_cmd_modify = 0;
    i_cmd_fault = 0;
    i_tbl_wr = 0;
    i_tbl_opcode = 0;
    i_tbl_data = 0;
    repeat (6) @(negedge i_clk);
    i_rst_n = 1;
    // Table is not reset, so load before any command
    for (int i = 0; i < 3; i++) begin
      i_tbl_wr = 1;
      i_tbl_opcode = 8'h10 + 8'(i);
      i_tbl_data = (i == 0) ? 2'b11 : (i == 1) ? 2'b01 : 2'b00;
      @(negedge i_clk);
    end
    i_tbl_wr = 0;
    t_owner();
    t_status();
    t_handover();
    t_power();
    end_of_test();
  end
endmodule // testbench

// [logic/maint_port_owner.v]
// Maintenance port ownership and general status encoding for commands
`include "maint_port_regs.vh"

// Behaviour
// - Owner session persists until reset or explicit release command.
// - Port-control opcode with operand one closes port, dropping owner.
// - Closed port accepts no host until operand zero re-arms it.
// - At most one host owns the maintenance connection at once.
// - Reply echoes bytes 0-3, status MSB/LSB in 4-5, zeros 6-7.
// - Successful service reports status 00.
// - Bad parameter reports 20, never the older 03.
// - Unknown path segment stops processing, reports 04.
// - Unknown class, instance or element stops processing, reports 05.
// - Unimplemented or undefined service reports 08.
// - Modifying a non-modifiable attribute reports 0E.
// - Reply larger than response space reports 11.
// - Too few data bytes reports 13, too many reports 15.
// - Unsupported attribute reports 14, missing object reports 16.
// - Device mode or state forbidding service reports 10.
// - Failed permission or privilege check reports 0F.
// - Partial data transfer reports 06, lost connection reports 07.
// - Unavailable resources report 02.
// - Splitting a primitive data value reports 12.
// - Extended status is reserved; reply carries none.
module maint_port_owner #(
  parameter HOST_W = 32,
  parameter LEN_W  = 8
) (
  input  wire                  i_clk,
  input  wire                  i_rst_n,
  // Command in
  input  wire                  i_cmd_valid,
  output wire                  o_cmd_ready,
  input  wire [63:0]           i_cmd_data,
  input  wire [LEN_W-1:0]      i_cmd_len,
  input  wire                  i_cmd_modify,
  input  wire [`MP_F_COUNT-1:0] i_cmd_fault,
  // Response out
  output reg                   o_rsp_valid,
  output reg  [63:0]           o_rsp_data,
  // Connection attempts on the maintenance port
  input  wire                  i_conn_req,
  input  wire [HOST_W-1:0]     i_conn_host,
  output wire                  o_conn_grant,
  output wire                  o_conn_refuse,
  // Port state towards the datagram stack
  output reg                   o_port_reset,
  output wire                  o_port_open,
  output reg                   o_owner_valid,
  output reg  [HOST_W-1:0]     o_owner_host,
  output wire [15:0]           o_port_num,
  // Service table load
  input  wire                  i_tbl_wr,
  input  wire [7:0]            i_tbl_opcode,
  input  wire [`MP_T_WIDTH-1:0] i_tbl_data
);

  localparam [1:0] ST_OPEN   = `MP_ST_OPEN;
  localparam [1:0] ST_OWNED  = `MP_ST_OWNED;
  localparam [1:0] ST_CLOSED = `MP_ST_CLOSED;
  localparam [1:0] PS_IDLE   = `MP_PS_IDLE;
  localparam [1:0] PS_LOOK   = `MP_PS_LOOK;
  localparam [1:0] PS_REPLY  = `MP_PS_REPLY;
  localparam [LEN_W-1:0] FULL_LEN = {{(LEN_W-4){1'b0}}, `MP_PAYLOAD_BYTES};

  reg  [1:0]              port_st_r;
  reg  [1:0]              port_st_nxt;
  reg  [1:0]              ps_r;
  reg  [1:0]              ps_nxt;
  reg  [63:0]             cmd_r;
  reg  [LEN_W-1:0]        len_r;
  reg                     modify_r;
  reg  [`MP_F_COUNT-1:0]  fault_r;
  reg  [7:0]              status_nxt;
  reg                     apply_nxt;
  reg  [HOST_W-1:0]       owner_nxt;
  reg                     owner_v_nxt;
  wire [`MP_T_WIDTH-1:0]  tbl_q;
  wire [7:0]              rsvd_b;
  wire [7:0]              type_b;
  wire [7:0]              opc_b;
  wire [7:0]              opnd_b;
  wire [31:0]             tail_b;
  wire                    is_port_ctrl;
  wire                    ctrl_fire;
  wire                    same_host;
  wire [7:0]              fault_code [0:`MP_F_COUNT-1];

  // Payload byte 0 is the first byte on the wire, held in the top lane
  assign rsvd_b = cmd_r[63:56];
  assign type_b = cmd_r[55:48];
  assign opc_b  = cmd_r[47:40];
  assign opnd_b = cmd_r[39:32];
  assign tail_b = cmd_r[31:0];

  assign is_port_ctrl = (opc_b == `MP_OPC_PORT_CTRL);
  assign o_cmd_ready  = (ps_r == PS_IDLE);
  assign o_port_open  = (port_st_r != ST_CLOSED);
  assign o_port_num   = `MP_UDP_PORT;

  svc_table_mem #(
    .AW (8),
    .DW (`MP_T_WIDTH)
  ) u_tbl (
    .i_clk     (i_clk),
    .i_wr_en   (i_tbl_wr),
    .i_wr_addr (i_tbl_opcode),
    .i_wr_data (i_tbl_data),
    .i_rd_addr (i_cmd_data[47:40]),
    .o_rd_data (tbl_q)
  );

  // Code per fault input, in the same order as the priority scan
  // path segment
  assign fault_code[`MP_F_PATH_SEG]    = `MP_GS_PATH_SEG;
  assign fault_code[`MP_F_PATH_DEST]   = `MP_GS_PATH_DEST;
  assign fault_code[`MP_F_NO_OBJECT]   = `MP_GS_NO_OBJECT;
  assign fault_code[`MP_F_PRIVILEGE]   = `MP_GS_PRIVILEGE;
  assign fault_code[`MP_F_DEV_STATE]   = `MP_GS_DEV_STATE;
  assign fault_code[`MP_F_RESOURCE]    = `MP_GS_RESOURCE;
  assign fault_code[`MP_F_NO_ATTR]     = `MP_GS_NO_ATTR;
  assign fault_code[`MP_F_REPLY_LARGE] = `MP_GS_REPLY_LARGE;
  assign fault_code[`MP_F_FRAGMENT]    = `MP_GS_FRAGMENT;
  assign fault_code[`MP_F_PARTIAL]     = `MP_GS_PARTIAL;
  assign fault_code[`MP_F_CONN_LOST]   = `MP_GS_CONN_LOST;

  // Status selection: length, format, fault inputs, then service checks
  always @* begin : status_sel
    integer k;
    reg     hit;
    k          = 0;
    status_nxt = `MP_GS_SUCCESS;
    hit        = 1'b0;
    if (len_r < FULL_LEN) begin
      status_nxt = `MP_GS_TOO_LITTLE;
      hit        = 1'b1;
    end else if (len_r > FULL_LEN) begin
      status_nxt = `MP_GS_TOO_MUCH;
      hit        = 1'b1;
    end else if (rsvd_b != `MP_RSVD_BYTE || type_b != `MP_MSG_TYPE ||
                 tail_b != 32'h0000_0000) begin
      status_nxt = `MP_GS_BAD_PARAM;
      hit        = 1'b1;
    end
    // first listed fault stops the scan
    for (k = 0; k < `MP_F_COUNT; k = k + 1) begin
      if (!hit && fault_r[k]) begin
        status_nxt = fault_code[k];
        hit        = 1'b1;
      end
    end
    if (!hit) begin
      if (is_port_ctrl) begin
        if (opnd_b != `MP_OPND_REARM && opnd_b != `MP_OPND_RELEASE) begin
          status_nxt = `MP_GS_BAD_PARAM;
        end
      end else if (!tbl_q[`MP_T_SUPPORTED]) begin
        status_nxt = `MP_GS_NO_SERVICE;
      end else if (modify_r && !tbl_q[`MP_T_SETTABLE]) begin
        status_nxt = `MP_GS_NOT_SETTABLE;
      end
    end
  end

  // Port control only takes effect when the whole command succeeds
  always @* begin
    apply_nxt = (ps_r == PS_LOOK) && is_port_ctrl &&
                (status_nxt == `MP_GS_SUCCESS);
  end

  assign ctrl_fire = apply_nxt;
  assign same_host = o_owner_valid && (i_conn_host == o_owner_host);

  // refuse others while owned or closed
  assign o_conn_grant  = i_conn_req && !ctrl_fire &&
                         ((port_st_r == ST_OPEN) ||
                          (port_st_r == ST_OWNED && same_host));
  assign o_conn_refuse = i_conn_req && !o_conn_grant;

  // Ownership state
  always @* begin
    port_st_nxt = port_st_r;
    owner_nxt   = o_owner_host;
    owner_v_nxt = o_owner_valid;
    case (port_st_r)
      ST_OPEN: begin
        // first connecting host becomes sole owner
        if (o_conn_grant) begin
          port_st_nxt = ST_OWNED;
          owner_nxt   = i_conn_host;
          owner_v_nxt = 1'b1;
        end
      end
      ST_OWNED: begin
        // session kept; reconnects from owner change nothing
        port_st_nxt = ST_OWNED;
      end
      ST_CLOSED: begin
        port_st_nxt = ST_CLOSED;
      end
      default: begin
        port_st_nxt = ST_CLOSED;
        owner_v_nxt = 1'b0;
      end
    endcase
    if (ctrl_fire) begin
      if (opnd_b == `MP_OPND_RELEASE) begin
        // release drops the owner and closes the port
        port_st_nxt = ST_CLOSED;
        owner_v_nxt = 1'b0;
        owner_nxt   = {HOST_W{1'b0}};
      end else if (port_st_r == ST_CLOSED) begin
        // re-arm opens for the next host
        port_st_nxt = ST_OPEN;
      end
    end
  end

  // Command pipeline
  always @* begin
    ps_nxt = ps_r;
    case (ps_r)
      PS_IDLE: begin
        if (i_cmd_valid) begin
          ps_nxt = PS_LOOK;
        end
      end
      PS_LOOK: begin
        ps_nxt = PS_REPLY;
      end
      PS_REPLY: begin
        ps_nxt = PS_IDLE;
      end
      default: begin
        ps_nxt = PS_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      // power-up leaves the port open for a first host
      port_st_r     <= ST_OPEN;
      ps_r          <= PS_IDLE;
      cmd_r         <= 64'h0000_0000_0000_0000;
      len_r         <= {LEN_W{1'b0}};
      modify_r      <= 1'b0;
      fault_r       <= {`MP_F_COUNT{1'b0}};
      o_owner_host  <= {HOST_W{1'b0}};
      o_owner_valid <= 1'b0;
      o_port_reset  <= 1'b0;
      o_rsp_valid   <= 1'b0;
      o_rsp_data    <= 64'h0000_0000_0000_0000;
    end else begin
      port_st_r     <= port_st_nxt;
      ps_r          <= ps_nxt;
      o_owner_host  <= owner_nxt;
      o_owner_valid <= owner_v_nxt;
      // Pulse lets the datagram stack flush the socket
      o_port_reset  <= ctrl_fire && (opnd_b == `MP_OPND_RELEASE);
      o_rsp_valid   <= (ps_r == PS_LOOK);
      if (ps_r == PS_IDLE && i_cmd_valid) begin
        cmd_r    <= i_cmd_data;
        len_r    <= i_cmd_len;
        modify_r <= i_cmd_modify;
        fault_r  <= i_cmd_fault;
      end
      if (ps_r == PS_LOOK) begin
        // echo header, status in bytes 4 and 5
        // success is a zero status word
        // extended status left reserved as zero
        o_rsp_data <= {cmd_r[63:32], 8'h00, status_nxt, 16'h0000};
      end
    end
  end

endmodule // maint_port_owner

// [logic/maint_port_regs.vh]
// Constants for the maintenance port owner and status encoder
`ifndef MAINT_PORT_REGS_VH
`define MAINT_PORT_REGS_VH

// Payload layout
`define MP_PAYLOAD_BYTES   4'h8
`define MP_MSG_TYPE        8'h02
`define MP_RSVD_BYTE       8'h00
`define MP_OPC_PORT_CTRL   8'hff
`define MP_OPND_REARM      8'h00
`define MP_OPND_RELEASE    8'h01
`define MP_UDP_PORT        16'h1e5f

// Port states
`define MP_ST_OPEN         2'h0
`define MP_ST_OWNED        2'h1
`define MP_ST_CLOSED       2'h2

// Command pipeline states
`define MP_PS_IDLE         2'h0
`define MP_PS_LOOK         2'h1
`define MP_PS_REPLY        2'h2

// General status codes
`define MP_GS_SUCCESS      8'h00
`define MP_GS_RESOURCE     8'h02
`define MP_GS_BAD_PARAM_OLD 8'h03
`define MP_GS_PATH_SEG     8'h04
`define MP_GS_PATH_DEST    8'h05
`define MP_GS_PARTIAL      8'h06
`define MP_GS_CONN_LOST    8'h07
`define MP_GS_NO_SERVICE   8'h08
`define MP_GS_NOT_SETTABLE 8'h0e
`define MP_GS_PRIVILEGE    8'h0f
`define MP_GS_DEV_STATE    8'h10
`define MP_GS_REPLY_LARGE  8'h11
`define MP_GS_FRAGMENT     8'h12
`define MP_GS_TOO_LITTLE   8'h13
`define MP_GS_NO_ATTR      8'h14
`define MP_GS_TOO_MUCH     8'h15
`define MP_GS_NO_OBJECT    8'h16
`define MP_GS_BAD_PARAM    8'h20

// Fault input bit positions, highest priority first after length and format checks
`define MP_F_PATH_SEG      0
`define MP_F_PATH_DEST     1
`define MP_F_NO_OBJECT     2
`define MP_F_PRIVILEGE     3
`define MP_F_DEV_STATE     4
`define MP_F_RESOURCE      5
`define MP_F_NO_ATTR       6
`define MP_F_REPLY_LARGE   7
`define MP_F_FRAGMENT      8
`define MP_F_PARTIAL       9
`define MP_F_CONN_LOST     10
`define MP_F_COUNT         11

// Service table entry bits
`define MP_T_SUPPORTED     0
`define MP_T_SETTABLE      1
`define MP_T_WIDTH         2

`endif

// [logic/svc_table_mem.v]
// Per-opcode service table with registered read data
module svc_table_mem #(
  parameter AW = 8,
  parameter DW = 2
) (
  input  wire          i_clk,
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [DW-1:0] i_wr_data,
  input  wire [AW-1:0] i_rd_addr,
  output reg  [DW-1:0] o_rd_data
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // No reset on the array: firmware loads it before use
  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem_r[i_rd_addr];
  end

endmodule // svc_table_mem
